// ===== core/arx_pkg.sv
// Shared constants and types for the address-filtering asynchronous receiver
package arx_pkg;

  // Register byte offsets, one aligned word each
  localparam logic [7:0] ARX_OFS_INT_CTRL  = 8'h00;
  localparam logic [7:0] ARX_OFS_IRQ_FLAGS = 8'h04;
  localparam logic [7:0] ARX_OFS_IRQ_EN    = 8'h08;
  localparam logic [7:0] ARX_OFS_IRQ_PRIO  = 8'h0c;
  localparam logic [7:0] ARX_OFS_RX_STCTL  = 8'h10;
  localparam logic [7:0] ARX_OFS_RX_DATA   = 8'h14;
  localparam logic [7:0] ARX_OFS_TX_STCTL  = 8'h18;
  localparam logic [7:0] ARX_OFS_BAUD_CTL  = 8'h1c;
  localparam logic [7:0] ARX_OFS_DIV_HIGH  = 8'h20;
  localparam logic [7:0] ARX_OFS_DIV_LOW   = 8'h24;

  // Field positions
  localparam int ARX_RXF_BIT     = 5;  // receive flag / enable / priority in the irq registers
  localparam int ARX_PORT_ON_BIT = 7;
  localparam int ARX_NINE_BIT    = 6;
  localparam int ARX_SREN_BIT    = 5;
  localparam int ARX_RXON_BIT    = 4;
  localparam int ARX_ADDR_BIT    = 3;
  localparam int ARX_FRAMING_ERROR_BIT    = 2;
  localparam int ARX_OVERRUN_ERROR_BIT    = 1;
  localparam int ARX_NINTH_BIT   = 0;
  localparam int ARX_CLKD_BIT    = 4;
  localparam int ARX_HSPD_BIT    = 2;
  localparam int ARX_TXEMPTY_BIT = 1;
  localparam int ARX_IDLE_BIT    = 6;
  localparam int ARX_WIDE_BIT    = 3;
  localparam int ARX_WUE_BIT     = 1;

  // Reset values and software-writable masks
  localparam logic [7:0] ARX_RST_BYTE      = 8'h00;
  localparam logic [7:0] ARX_TX_STCTL_MASK = 8'hfd;
  localparam logic [7:0] ARX_BAUD_RW_MASK  = 8'h19;
  localparam logic [7:0] ARX_FLAGS_RW_MASK = 8'hdf;

  // Sampling counts
  localparam logic [3:0] ARX_MID_SAMPLE  = 4'h7;
  localparam logic [3:0] ARX_LAST_SAMPLE = 4'hf;
  localparam logic [3:0] ARX_BITS_8      = 4'h7;
  localparam logic [3:0] ARX_BITS_9      = 4'h8;
  localparam logic [1:0] ARX_X64_LAST    = 2'h3;

  typedef enum logic [1:0] {
    ARX_IDLE  = 2'b00,
    ARX_START = 2'b01,
    ARX_DATA  = 2'b10,
    ARX_STOP  = 2'b11
  } arx_rx_state_t;

  typedef struct packed {
    logic [8:0] data;
    logic       frame_ok;
  } arx_char_t;

  typedef struct packed {
    logic [15:0] divisor;
    logic        high_speed;
    logic        wide;
  } arx_baud_cfg_t;

endpackage

// ===== core/arx_baud_gen.sv
// Baud generator producing the sixteen-per-bit sample tick
`timescale 1ns/100ps
module arx_baud_gen (
  // Clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // Control
  input  wire logic                   run,
  input  arx_pkg::arx_baud_cfg_t      cfg,
  // Sample tick
  output logic                        tick_q
);
  logic [15:0] cnt_q;
  logic [1:0]  pre_q;
  logic [15:0] div;
  logic        x64;

  // Narrow divisor uses the low byte only
  assign div = cfg.wide ? cfg.divisor : {8'h00, cfg.divisor[7:0]};
  assign x64 = ~cfg.wide & ~cfg.high_speed;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= 16'h0000;
      pre_q  <= 2'h0;
      tick_q <= 1'b0;
    end else if (!run) begin
      cnt_q  <= 16'h0000;
      pre_q  <= 2'h0;
      tick_q <= 1'b0;
    end else if (cnt_q == 16'h0000) begin
      cnt_q  <= div;
      pre_q  <= x64 ? pre_q + 2'h1 : 2'h0;
      tick_q <= ~x64 | (pre_q == arx_pkg::ARX_X64_LAST);
    end else begin
      cnt_q  <= cnt_q - 16'h0001;
      tick_q <= 1'b0;
    end
  end
endmodule

// ===== core/arx_rx_shift.sv
// Data recovery and receive shifter for one framed character
`timescale 1ns/100ps
module arx_rx_shift (
  // Clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // Control
  input  wire logic                   run,
  input  wire logic                   tick,
  input  wire logic                   nine,
  input  wire logic                   rx_s,
  // Result
  output arx_pkg::arx_char_t          char_q,
  output logic                        done_q,
  output logic                        idle
);
  arx_pkg::arx_rx_state_t st_q;
  logic [3:0] smp_q;
  logic [3:0] bit_q;
  logic [8:0] shf_q;

  assign idle = (st_q == arx_pkg::ARX_IDLE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q   <= arx_pkg::ARX_IDLE;
      smp_q  <= 4'h0;
      bit_q  <= 4'h0;
      shf_q  <= 9'h000;
      char_q <= '0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (!run) begin
        st_q <= arx_pkg::ARX_IDLE;
      end else if (tick) begin
        case (st_q)
          arx_pkg::ARX_IDLE: begin
            smp_q <= 4'h0;
            if (!rx_s) st_q <= arx_pkg::ARX_START;
          end
          arx_pkg::ARX_START: begin
            smp_q <= smp_q + 4'h1;
            if (smp_q == arx_pkg::ARX_MID_SAMPLE) begin
              // A start glitch shorter than half a bit is dropped
              st_q  <= rx_s ? arx_pkg::ARX_IDLE : arx_pkg::ARX_DATA;
              smp_q <= 4'h0;
              bit_q <= 4'h0;
            end
          end
          arx_pkg::ARX_DATA: begin
            smp_q <= smp_q + 4'h1;
            if (smp_q == arx_pkg::ARX_LAST_SAMPLE) begin
              shf_q <= {rx_s, shf_q[8:1]};
              bit_q <= bit_q + 4'h1;
              if (bit_q == (nine ? arx_pkg::ARX_BITS_9 : arx_pkg::ARX_BITS_8)) st_q <= arx_pkg::ARX_STOP;
            end
          end
          arx_pkg::ARX_STOP: begin
            smp_q <= smp_q + 4'h1;
            if (smp_q == arx_pkg::ARX_LAST_SAMPLE) begin
              char_q.data     <= nine ? shf_q : {1'b0, shf_q[8:1]};
              char_q.frame_ok <= rx_s;
              done_q          <= 1'b1;
              st_q            <= arx_pkg::ARX_IDLE;
            end
          end
          default: st_q <= arx_pkg::ARX_IDLE;
        endcase
      end
    end
  end
endmodule

// ===== core/arx_receiver.sv
// APB-attached asynchronous receiver with address filter and wake-on-edge
//
// Summary of operation
// - Recover data with sixteen samples per bit, shifting once per bit.
// - Reception runs only with clocked mode clear and the port on.
// - Nine-bit mode receives nine data bits per character.
// - Characters are received only while receiver_on is set.
// - A completed character sets the receive flag; enabled flag requests interrupt.
// - The ninth received bit is readable in the receive status register.
// - The low eight data bits are readable in receive_data.
// - Clearing receiver_on clears framing and overrun errors.
// - The receive interrupt priority is chosen by receive_irq_priority.
// - Nine-bit with address filter drops non-address characters, no flag.
// - In sleep the baud generator stops and no character is received.
// - wake_on_edge_enable, bit 1 of baud_control, arms wake only when asynchronous.
// - While armed, normal reception is held idle and the pin watched.
// - A falling edge on the receive pin is the wake event.
// - The wake event sets the receive flag, running or asleep.
// - Reading receive_data clears the flag raised by the wake event.
// - First rising edge after the wake event clears wake_on_edge_enable.
// - Frame is start, eight or nine data bits, stop; LSB first.
// - Baud generator runs at sixteen or sixty-four times the bit rate.
`timescale 1ns/100ps
module arx_receiver #(
  parameter int APB_AW = 8
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata_q,
  output logic                   pready_q,
  output logic                   pslverr_q,
  // Serial line and power state
  input  wire logic              receive_pin,
  input  wire logic              sleep_mode,
  // Requests to the core
  output logic                   irq_high_q,
  output logic                   irq_low_q,
  output logic                   wake_q
);
  // Register state
  logic [7:0] int_ctrl_q;
  logic [7:0] flags_rw_q;
  logic       receive_flag_q;
  logic [7:0] irq_en_q;
  logic [7:0] irq_prio_q;
  logic       serial_port_on_q;
  logic       nine_bit_receive_q;
  logic       single_rx_q;
  logic       receiver_on_q;
  logic       address_filter_on_q;
  logic       framing_error_q;
  logic       overrun_error_q;
  logic       received_ninth_bit_q;
  logic [7:0] receive_data_q;
  logic [7:0] tx_stctl_q;
  logic [7:0] baud_rw_q;
  logic       wake_on_edge_enable_q;
  logic [7:0] div_high_q;
  logic [7:0] div_low_q;

  // Pin synchroniser and edge history
  logic       rx_meta_q;
  logic       rx_sync_q;
  logic       rx_prev_q;
  logic       wake_seen_q;

  // Internal nets
  logic                   apb_setup;
  logic                   apb_done;
  logic                   wr_en;
  logic                   rd_en;
  logic                   addr_hit;
  logic [7:0]             rd_byte;
  logic                   async_mode;
  logic                   wake_armed;
  logic                   rx_run;
  logic                   baud_run;
  logic                   sample_tick;
  logic                   char_done;
  logic                   rx_idle;
  logic                   fall_edge;
  logic                   rise_edge;
  logic                   wake_event;
  logic                   wake_end;
  logic                   pass_filter;
  logic                   char_load;
  logic                   char_overrun;
  logic                   receive_data_read;
  logic                   rxon_clear;
  logic [7:0]             wbyte;
  arx_pkg::arx_char_t     rx_char;
  arx_pkg::arx_baud_cfg_t baud_cfg;

  // Bus decode; every access completes with no wait state
  assign apb_setup = psel & ~penable & ~pready_q;
  assign apb_done  = psel & penable & pready_q;
  assign wr_en     = apb_done & pwrite & addr_hit;
  assign rd_en     = apb_done & ~pwrite & addr_hit;
  assign wbyte     = pwdata[7:0];

  always_comb begin
    addr_hit = 1'b1;
    rd_byte  = 8'h00;
    case (paddr[7:0])
      arx_pkg::ARX_OFS_INT_CTRL:  rd_byte = int_ctrl_q;
      arx_pkg::ARX_OFS_IRQ_FLAGS: begin
        rd_byte                       = flags_rw_q;
        rd_byte[arx_pkg::ARX_RXF_BIT] = receive_flag_q;
      end
      arx_pkg::ARX_OFS_IRQ_EN:    rd_byte = irq_en_q;
      arx_pkg::ARX_OFS_IRQ_PRIO:  rd_byte = irq_prio_q;
      arx_pkg::ARX_OFS_RX_STCTL:  rd_byte = {serial_port_on_q, nine_bit_receive_q, single_rx_q, receiver_on_q,
                                             address_filter_on_q, framing_error_q, overrun_error_q,
                                             received_ninth_bit_q};
      arx_pkg::ARX_OFS_RX_DATA:   rd_byte = receive_data_q;
      arx_pkg::ARX_OFS_TX_STCTL: begin
        rd_byte                           = tx_stctl_q;
        rd_byte[arx_pkg::ARX_TXEMPTY_BIT] = 1'b1;
      end
      arx_pkg::ARX_OFS_BAUD_CTL: begin
        rd_byte                       = baud_rw_q;
        rd_byte[arx_pkg::ARX_IDLE_BIT] = rx_idle & ~wake_armed;
        rd_byte[arx_pkg::ARX_WUE_BIT]  = wake_on_edge_enable_q;
      end
      arx_pkg::ARX_OFS_DIV_HIGH:  rd_byte = div_high_q;
      arx_pkg::ARX_OFS_DIV_LOW:   rd_byte = div_low_q;
      default:                    addr_hit = 1'b0;
    endcase
    if ((paddr >> 8) != '0) addr_hit = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= apb_setup;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_q <= 1'b0;
    end else begin
      pslverr_q <= apb_setup & ~addr_hit;
    end
  end

  // Data bus is driven only in the answer cycle, zero otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else begin
      prdata_q <= (apb_setup & ~pwrite & addr_hit) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // Mode decode
  assign async_mode = serial_port_on_q & ~tx_stctl_q[arx_pkg::ARX_CLKD_BIT];
  assign wake_armed = wake_on_edge_enable_q & async_mode;
  assign rx_run     = async_mode & receiver_on_q & ~wake_armed & ~sleep_mode;
  assign baud_run   = serial_port_on_q & ~sleep_mode;
  assign baud_cfg   = '{divisor: {div_high_q, div_low_q},
                        high_speed: tx_stctl_q[arx_pkg::ARX_HSPD_BIT],
                        wide: baud_rw_q[arx_pkg::ARX_WIDE_BIT]};

  arx_baud_gen u_baud (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (baud_run),
    .cfg     (baud_cfg),
    .tick_q  (sample_tick)
  );

  arx_rx_shift u_shift (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (rx_run),
    .tick    (sample_tick),
    .nine    (nine_bit_receive_q),
    .rx_s    (rx_sync_q),
    .char_q  (rx_char),
    .done_q  (char_done),
    .idle    (rx_idle)
  );

  // Receive pin passes two flops before anything looks at it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
      rx_prev_q <= 1'b1;
    end else begin
      rx_meta_q <= receive_pin;
      rx_sync_q <= rx_meta_q;
      rx_prev_q <= rx_sync_q;
    end
  end

  assign fall_edge  = rx_prev_q & ~rx_sync_q;
  assign rise_edge  = ~rx_prev_q & rx_sync_q;
  assign wake_event = wake_armed & ~wake_seen_q & fall_edge;
  // Relies on the sender holding the line low for the whole wake character
  assign wake_end   = wake_armed & wake_seen_q & rise_edge;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_seen_q <= 1'b0;
    end else if (!wake_armed || wake_end) begin
      wake_seen_q <= 1'b0;
    end else if (wake_event) begin
      wake_seen_q <= 1'b1;
    end
  end

  // Clock keeps running here, so the sleeping case just forwards the event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= wake_event & sleep_mode;
    end
  end

  // Character acceptance
  assign pass_filter  = ~(nine_bit_receive_q & address_filter_on_q) | rx_char.data[8];
  assign char_overrun = char_done & pass_filter & receive_flag_q;
  assign char_load    = char_done & pass_filter & ~receive_flag_q;
  assign receive_data_read   = rd_en & (paddr[7:0] == arx_pkg::ARX_OFS_RX_DATA);
  assign rxon_clear   = wr_en & (paddr[7:0] == arx_pkg::ARX_OFS_RX_STCTL) & ~wbyte[arx_pkg::ARX_RXON_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receive_data_q       <= arx_pkg::ARX_RST_BYTE;
      received_ninth_bit_q <= 1'b0;
    end else if (char_load) begin
      receive_data_q       <= rx_char.data[7:0];
      received_ninth_bit_q <= rx_char.data[8];
    end
  end

  // Flag set wins over a clearing read in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receive_flag_q <= 1'b0;
    end else if (char_load || wake_event) begin
      receive_flag_q <= 1'b1;
    end else if (receive_data_read) begin
      receive_flag_q <= 1'b0;
    end
  end

  // A character ending as receiver_on is cleared still reports its error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      framing_error_q <= 1'b0;
    end else if (char_load) begin
      framing_error_q <= ~rx_char.frame_ok;
    end else if (rxon_clear) begin
      framing_error_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun_error_q <= 1'b0;
    end else if (char_overrun) begin
      overrun_error_q <= 1'b1;
    end else if (rxon_clear) begin
      overrun_error_q <= 1'b0;
    end
  end

  // Software control of the receive status register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_port_on_q    <= 1'b0;
      nine_bit_receive_q  <= 1'b0;
      single_rx_q         <= 1'b0;
      receiver_on_q       <= 1'b0;
      address_filter_on_q <= 1'b0;
    end else if (wr_en && paddr[7:0] == arx_pkg::ARX_OFS_RX_STCTL) begin
      serial_port_on_q    <= wbyte[arx_pkg::ARX_PORT_ON_BIT];
      nine_bit_receive_q  <= wbyte[arx_pkg::ARX_NINE_BIT];
      single_rx_q         <= wbyte[arx_pkg::ARX_SREN_BIT];
      receiver_on_q       <= wbyte[arx_pkg::ARX_RXON_BIT];
      address_filter_on_q <= wbyte[arx_pkg::ARX_ADDR_BIT];
    end
  end

  // Wake enable: hardware clear at the end of the break beats a write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_on_edge_enable_q <= 1'b0;
    end else if (wake_end) begin
      wake_on_edge_enable_q <= 1'b0;
    end else if (wr_en && paddr[7:0] == arx_pkg::ARX_OFS_BAUD_CTL) begin
      wake_on_edge_enable_q <= wbyte[arx_pkg::ARX_WUE_BIT];
    end
  end

  // Plain read/write configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_ctrl_q <= arx_pkg::ARX_RST_BYTE;
      flags_rw_q <= arx_pkg::ARX_RST_BYTE;
      irq_en_q   <= arx_pkg::ARX_RST_BYTE;
      irq_prio_q <= arx_pkg::ARX_RST_BYTE;
      tx_stctl_q <= arx_pkg::ARX_RST_BYTE;
      baud_rw_q  <= arx_pkg::ARX_RST_BYTE;
      div_high_q <= arx_pkg::ARX_RST_BYTE;
      div_low_q  <= arx_pkg::ARX_RST_BYTE;
    end else if (wr_en) begin
      case (paddr[7:0])
        arx_pkg::ARX_OFS_INT_CTRL:  int_ctrl_q <= wbyte;
        arx_pkg::ARX_OFS_IRQ_FLAGS: flags_rw_q <= wbyte & arx_pkg::ARX_FLAGS_RW_MASK;
        arx_pkg::ARX_OFS_IRQ_EN:    irq_en_q   <= wbyte;
        arx_pkg::ARX_OFS_IRQ_PRIO:  irq_prio_q <= wbyte;
        arx_pkg::ARX_OFS_TX_STCTL:  tx_stctl_q <= wbyte & arx_pkg::ARX_TX_STCTL_MASK;
        arx_pkg::ARX_OFS_BAUD_CTL:  baud_rw_q  <= wbyte & arx_pkg::ARX_BAUD_RW_MASK;
        arx_pkg::ARX_OFS_DIV_HIGH:  div_high_q <= wbyte;
        arx_pkg::ARX_OFS_DIV_LOW:   div_low_q  <= wbyte;
        default:                    div_low_q  <= div_low_q;
      endcase
    end
  end

  // Interrupt requests split by the priority bit; global gating is up to the core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_high_q <= 1'b0;
      irq_low_q  <= 1'b0;
    end else begin
      irq_high_q <= receive_flag_q & irq_en_q[arx_pkg::ARX_RXF_BIT] & irq_prio_q[arx_pkg::ARX_RXF_BIT];
      irq_low_q  <= receive_flag_q & irq_en_q[arx_pkg::ARX_RXF_BIT] & ~irq_prio_q[arx_pkg::ARX_RXF_BIT];
    end
  end

endmodule

// ===== verif/arx_receiver_monitor.sv
// Checker for the receiver's bus timing and request outputs
`timescale 1ns/100ps
module arx_receiver_monitor #(
  parameter int APB_AW = 8
) (
  // Clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // Bus
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata_q,
  input wire logic              pready_q,
  input wire logic              pslverr_q,
  // Line and requests
  input wire logic              receive_pin,
  input wire logic              sleep_mode,
  input wire logic              irq_high_q,
  input wire logic              irq_low_q,
  input wire logic              wake_q
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic mapped;
  logic irq_any;
  assign mapped  = (paddr[1:0] == 2'h0) && (paddr <= APB_AW'(8'h24));
  assign irq_any = irq_high_q | irq_low_q;

  a_ready_timing: assert property (psel && !penable |=> pready_q ##1 !pready_q)
    else $error("ready not in first access cycle");
  a_ready_single: assert property (pready_q |=> !pready_q)
    else $error("ready held too long");
  a_ready_access: assert property (pready_q |-> psel && penable)
    else $error("ready outside an access");
  a_err_decode: assert property (pready_q |-> pslverr_q == !mapped)
    else $error("slave error does not match address");
  a_err_quiet: assert property (pslverr_q |-> pready_q && prdata_q == 32'h0)
    else $error("slave error without ready or with data");
  a_rdata_idle: assert property (!pready_q |-> prdata_q == 32'h0)
    else $error("read data outside answer");
  a_irq_exclusive: assert property (!(irq_high_q && irq_low_q))
    else $error("both priority requests high");
  // Only a completed bus access may take a pending request away
  a_irq_held: assert property (irq_any && !psel && !$past(psel) |=> irq_any)
    else $error("request dropped without access");
  a_wake_pulse: assert property (wake_q |-> $past(sleep_mode) ##1 !wake_q)
    else $error("wake pulse wrong");

  c_irq_low: cover property ($rose(irq_low_q));
  c_irq_high: cover property ($rose(irq_high_q));
  c_wake: cover property (wake_q);
  c_unmapped: cover property (pslverr_q);
endmodule

bind arx_receiver arx_receiver_monitor #(.APB_AW(APB_AW)) u_monitor (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
  .receive_pin(receive_pin), .sleep_mode(sleep_mode), .irq_high_q(irq_high_q), .irq_low_q(irq_low_q),
  .wake_q(wake_q));

// ===== verif/arx_line_model.sv
// Behavioural remote transmitter driving the receive line
`timescale 1ns/100ps
module arx_line_model #(
  parameter int BIT_CYC = 32
) (
  // Clock
  input wire logic pclk,
  // Serial line
  output logic     receive_pin
);
  int bit_cyc = BIT_CYC;

  initial receive_pin = 1'b1;

  task automatic hold(input logic v, input int cyc);
    receive_pin <= v;
    repeat (cyc) @(posedge pclk);
  endtask

  // A low stop bit ends three quarters in, so the false start it leaves is dropped
  task automatic send(input logic [8:0] d, input int nb, input logic stop);
    hold(1'b0, bit_cyc);
    for (int i = 0; i < nb; i++) hold(d[i], bit_cyc);
    hold(stop, bit_cyc * 3 / 4);
    hold(1'b1, bit_cyc / 4 + 2 * bit_cyc);
  endtask
endmodule

// ===== verif/testbench.sv
// Self-checking bench for the address-filtering serial receiver
`timescale 1ns/100ps
module testbench;
  localparam logic [7:0] RXS = arx_pkg::ARX_OFS_RX_STCTL, DAT = arx_pkg::ARX_OFS_RX_DATA;
  localparam logic [7:0] FLG = arx_pkg::ARX_OFS_IRQ_FLAGS, IEN = arx_pkg::ARX_OFS_IRQ_EN;
  localparam logic [7:0] PRI = arx_pkg::ARX_OFS_IRQ_PRIO, TXS = arx_pkg::ARX_OFS_TX_STCTL;
  localparam logic [7:0] BDC = arx_pkg::ARX_OFS_BAUD_CTL, DVL = arx_pkg::ARX_OFS_DIV_LOW;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic        receive_pin;
  logic        sleep_mode = 1'b0;
  logic        irq_high_q;
  logic        irq_low_q;
  logic        wake_q;
  logic [7:0]  rv;
  logic        serr;
  int          err_total = 0;
  int          compares = 0;
  int          wakes = 0;

  always #2.5 pclk = ~pclk;
  always @(posedge pclk) if (wake_q === 1'b1) wakes <= wakes + 1;

  arx_receiver #(.APB_AW(8)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
    .receive_pin(receive_pin), .sleep_mode(sleep_mode), .irq_high_q(irq_high_q), .irq_low_q(irq_low_q),
    .wake_q(wake_q));
  arx_line_model #(.BIT_CYC(32)) i_line (.pclk(pclk), .receive_pin(receive_pin));

  task automatic results();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Idle cycle first, so no strobe is assigned twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready_q !== 1'b1 && n < 40);
    rv = prdata_q[7:0];
    serr = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready_q !== 1'b1) begin
      err_total++;
      results();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] exp, input string what);
    apb(1'b0, a, 8'h00);
    chk(what, rv, exp);
  endtask

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rc(RXS, 8'h00, "status reset");
    rc(TXS, 8'h02, "tx status reset");
    rc(8'h28, 8'h00, "unmapped");
    chk("slave error", {7'h00, serr}, 8'h01);
    wr(DVL, 8'h01);
    rc(DVL, 8'h01, "divisor low");
    chk("no slave error", {7'h00, serr}, 8'h00);
    wr(TXS, 8'h04);
    wr(IEN, 8'h20);
    wr(RXS, 8'h90);
    i_line.send(9'h0a5, 8, 1'b1);
    chk("irq low", {7'h00, irq_low_q}, 8'h01);
    chk("irq high", {7'h00, irq_high_q}, 8'h00);
    rc(FLG, 8'h20, "flag set");
    rc(DAT, 8'ha5, "data");
    rc(FLG, 8'h00, "flag after read");
    wr(PRI, 8'h20);
    i_line.send(9'h03c, 8, 1'b1);
    chk("irq high", {7'h00, irq_high_q}, 8'h01);
    rc(DAT, 8'h3c, "data high prio");
    wr(RXS, 8'hd0);
    i_line.send(9'h15a, 9, 1'b1);
    rc(RXS, 8'hd1, "ninth bit");
    rc(DAT, 8'h5a, "nine data");
    wr(RXS, 8'hd8);
    i_line.send(9'h033, 9, 1'b1);
    rc(FLG, 8'h00, "filtered");
    i_line.send(9'h144, 9, 1'b1);
    rc(DAT, 8'h44, "address");
    wr(RXS, 8'hd0);
    i_line.send(9'h055, 9, 1'b1);
    rc(DAT, 8'h55, "after filter");
    wr(RXS, 8'h90);
    i_line.send(9'h0ff, 8, 1'b0);
    rc(RXS, 8'h94, "framing");
    rc(DAT, 8'hff, "framed data");
    i_line.send(9'h011, 8, 1'b1);
    i_line.send(9'h022, 8, 1'b1);
    rc(RXS, 8'h92, "overrun");
    rc(DAT, 8'h11, "kept data");
    wr(RXS, 8'h80);
    rc(RXS, 8'h80, "errors cleared");
    i_line.send(9'h066, 8, 1'b1);
    rc(FLG, 8'h00, "receiver off");
    wr(TXS, 8'h14);
    wr(RXS, 8'h90);
    i_line.send(9'h077, 8, 1'b1);
    rc(FLG, 8'h00, "clocked mode");
    wr(TXS, 8'h04);
    sleep_mode <= 1'b1;
    i_line.send(9'h088, 8, 1'b1);
    sleep_mode <= 1'b0;
    rc(FLG, 8'h00, "asleep");
    wr(BDC, 8'h02);
    sleep_mode <= 1'b1;
    i_line.send(9'h000, 8, 1'b1);
    sleep_mode <= 1'b0;
    chk("wake pulses", wakes[7:0], 8'h01);
    rc(FLG, 8'h20, "wake flag");
    apb(1'b0, BDC, 8'h00);
    chk("wake enable", rv & 8'h02, 8'h00);
    rc(DAT, 8'h11, "wake data");
    rc(FLG, 8'h00, "wake read");
    i_line.send(9'h099, 8, 1'b1);
    rc(DAT, 8'h99, "normal again");
    wr(DVL, 8'h00);
    wr(TXS, 8'h00);
    i_line.bit_cyc = 64;
    i_line.send(9'h0c3, 8, 1'b1);
    rc(DAT, 8'hc3, "sixty-four rate");
    results();
  end
endmodule
